/* hdl/cdc_dma.sv */
// Converter DMA configuration and collection engine top.
// Assumes a processor register port with one-cycle strobes and read data one cycle later.
//
// The implementer's own choice: strobed register access.
`timescale 1ns/1ns
module cdc_dma (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic arst_n,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // Converter results
  input cdc_pkg::cdc_result_t first_res,
  input cdc_pkg::cdc_result_t second_res,
  input cdc_pkg::cdc_result_t diff_res,
  // External data RAM write
  output cdc_pkg::cdc_ram_wr_t ram_wr,
  // Interrupt requests
  output logic overflow_irq,
  output logic end_op_irq
);
  // ==========================================================================
  // Register state
  logic [7:0] data_addr_start_high_q;
  logic [7:0] instr_q;
  logic [7:0] repeat_limit_q;
  logic overflow_irq_enable_q;
  logic end_op_irq_enable_q;
  logic overflow_flag_q;
  logic end_op_flag_q;
  logic [7:0] repeat_cnt_q;
  logic [7:0] addr_low_q;
  logic [7:0] rdata_q;
  cdc_pkg::cdc_ram_wr_t ram_wr_q;
  cdc_pkg::cdc_state_t state_q;
  cdc_pkg::cdc_state_t state_d;

  // ==========================================================================
  // Address decode
  logic wr_start_high;
  logic wr_cfg;
  logic wr_instr;
  logic wr_limit;
  logic wr_ctrl;
  assign wr_start_high = reg_wr & (reg_addr == cdc_pkg::ADDR_DATA_START_HIGH);
  assign wr_cfg = reg_wr & (reg_addr == cdc_pkg::ADDR_TRANSFER_CONFIG);
  assign wr_instr = reg_wr & (reg_addr == cdc_pkg::ADDR_INSTR_WORD);
  assign wr_limit = reg_wr & (reg_addr == cdc_pkg::ADDR_REPEAT_LIMIT);
  assign wr_ctrl = reg_wr & (reg_addr == cdc_pkg::ADDR_ENGINE_CTRL);

  // Instruction fields; reserved low bits are ignored by the engine
  logic ins_first;
  logic ins_second;
  logic ins_diff;
  logic ins_cont;
  logic ins_end_op;
  assign ins_first = instr_q[cdc_pkg::INS_FIRST_BIT];
  assign ins_second = instr_q[cdc_pkg::INS_SECOND_BIT];
  assign ins_diff = instr_q[cdc_pkg::INS_DIFF_BIT];
  assign ins_cont = instr_q[cdc_pkg::INS_CONT_BIT];
  // An instruction with no collect bits and no continuous bit set marks the end of the operation
  assign ins_end_op = ((instr_q & ~cdc_pkg::INSTR_RESV_MASK) == cdc_pkg::INSTR_END_OP);

  // ==========================================================================
  // Collection selection
  logic store_valid;
  logic [15:0] store_data;
  cdc_collect u_collect (
    .first_en(ins_first),
    .second_en(ins_second),
    .diff_en(ins_diff),
    .first_res(first_res),
    .second_res(second_res),
    .diff_res(diff_res),
    .store_valid(store_valid),
    .store_data(store_data)
  );

  // ==========================================================================
  // Engine sequencing
  logic start;
  logic running;
  logic do_store;
  logic cnt_wrap;
  logic overflow_evt;
  logic end_op_evt;
  assign start = wr_ctrl & reg_wdata[cdc_pkg::CTL_START_BIT];
  assign running = (state_q == cdc_pkg::CDC_WAIT);
  assign do_store = running & store_valid;
  assign cnt_wrap = (repeat_cnt_q + 8'h01) >= repeat_limit_q;
  // Overflow only counts in non-continuous mode
  assign overflow_evt = do_store & ~ins_cont & cnt_wrap;
  assign end_op_evt = start & ins_end_op;

  // Next state
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      cdc_pkg::CDC_IDLE: begin
        if (start && !ins_end_op) begin
          state_d = cdc_pkg::CDC_WAIT;
        end
      end
      cdc_pkg::CDC_WAIT: begin
        if (overflow_evt) begin
          state_d = cdc_pkg::CDC_DONE;
        end
      end
      cdc_pkg::CDC_DONE: begin
        state_d = cdc_pkg::CDC_IDLE;
      end
      default: begin
        state_d = cdc_pkg::CDC_IDLE;
      end
    endcase
  end

  // ==========================================================================
  // Sticky flags
  logic clr_ovf;
  logic clr_eop;
  assign clr_ovf = wr_cfg & ~reg_wdata[cdc_pkg::CFG_OVF_FLAG_BIT];
  assign clr_eop = wr_cfg & ~reg_wdata[cdc_pkg::CFG_EOP_FLAG_BIT];
  cdc_flag u_ovf_flag (
    .ref_clk(ref_clk),
    .arst_n(arst_n),
    .set_i(overflow_evt),
    .clr_i(clr_ovf),
    .flag_q(overflow_flag_q)
  );
  cdc_flag u_eop_flag (
    .ref_clk(ref_clk),
    .arst_n(arst_n),
    .set_i(end_op_evt),
    .clr_i(clr_eop),
    .flag_q(end_op_flag_q)
  );

  // Interrupts are gated by their enables
  assign overflow_irq = overflow_flag_q & overflow_irq_enable_q;
  assign end_op_irq = end_op_flag_q & end_op_irq_enable_q;

  // ==========================================================================
  // Software registers
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      data_addr_start_high_q <= cdc_pkg::RST_BYTE;
      instr_q <= cdc_pkg::RST_BYTE;
      repeat_limit_q <= cdc_pkg::RST_REPEAT_LIMIT;
      overflow_irq_enable_q <= 1'b0;
      end_op_irq_enable_q <= 1'b0;
    end else begin
      if (wr_start_high) begin
        data_addr_start_high_q <= reg_wdata;
      end
      if (wr_instr) begin
        instr_q <= reg_wdata; // Low bits kept as written; engine ignores them
      end
      if (wr_limit) begin
        repeat_limit_q <= reg_wdata;
      end
      if (wr_cfg) begin
        overflow_irq_enable_q <= reg_wdata[cdc_pkg::CFG_OVF_IE_BIT];
        end_op_irq_enable_q <= reg_wdata[cdc_pkg::CFG_EOP_IE_BIT];
      end
    end
  end

  // ==========================================================================
  // Engine state, repeat counter and RAM address
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      state_q <= cdc_pkg::CDC_IDLE;
      repeat_cnt_q <= cdc_pkg::RST_BYTE;
      addr_low_q <= cdc_pkg::RST_BYTE;
    end else begin
      state_q <= state_d;
      if (start) begin
        repeat_cnt_q <= cdc_pkg::RST_BYTE;
        addr_low_q <= cdc_pkg::RST_BYTE;
      end else if (do_store) begin
        repeat_cnt_q <= overflow_evt ? cdc_pkg::RST_BYTE : repeat_cnt_q + 8'h01;
        addr_low_q <= addr_low_q + 8'h01;
      end
    end
  end

  // ==========================================================================
  // External RAM write; one word per stored result
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      ram_wr_q <= '0;
    end else begin
      ram_wr_q.valid <= do_store;
      ram_wr_q.addr <= {data_addr_start_high_q, addr_low_q};
      ram_wr_q.data <= store_data;
    end
  end
  assign ram_wr = ram_wr_q;

  // ==========================================================================
  // Read mux; unmapped addresses read zero
  logic [7:0] cfg_rd;
  logic [7:0] rd_mux;
  assign cfg_rd = {4'h0, overflow_irq_enable_q, overflow_flag_q, end_op_irq_enable_q, end_op_flag_q};
  assign rd_mux = (reg_addr == cdc_pkg::ADDR_DATA_START_HIGH) ? data_addr_start_high_q :
                  (reg_addr == cdc_pkg::ADDR_TRANSFER_CONFIG) ? cfg_rd :
                  (reg_addr == cdc_pkg::ADDR_INSTR_WORD) ? instr_q :
                  (reg_addr == cdc_pkg::ADDR_REPEAT_LIMIT) ? repeat_limit_q :
                  (reg_addr == cdc_pkg::ADDR_ENGINE_STATUS) ? {6'h00, state_q} :
                  8'h00;
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      rdata_q <= cdc_pkg::RST_BYTE;
    end else begin
      rdata_q <= reg_rd ? rd_mux : 8'h00;
    end
  end
  assign reg_rdata = rdata_q;
endmodule // cdc_dma

/* hdl/cdc_pkg.sv */
// Package for the converter DMA configuration block: register offsets, field positions, reset values, types.
// Assumes an 8-bit processor register port with word offsets as printed.
package cdc_pkg;
  // ==========================================================================
  // Register offsets
  localparam logic [7:0] ADDR_DATA_START_HIGH = 8'hDA;
  localparam logic [7:0] ADDR_TRANSFER_CONFIG = 8'hD8;
  localparam logic [7:0] ADDR_INSTR_WORD = 8'hD9;
  localparam logic [7:0] ADDR_REPEAT_LIMIT = 8'hDB;
  localparam logic [7:0] ADDR_ENGINE_CTRL = 8'hDC;
  localparam logic [7:0] ADDR_ENGINE_STATUS = 8'hDD;
  // ==========================================================================
  // Configuration register fields
  localparam int CFG_EOP_FLAG_BIT = 0;
  localparam int CFG_EOP_IE_BIT = 1;
  localparam int CFG_OVF_FLAG_BIT = 2;
  localparam int CFG_OVF_IE_BIT = 3;
  // Instruction word fields
  localparam int INS_FIRST_BIT = 4;
  localparam int INS_SECOND_BIT = 5;
  localparam int INS_DIFF_BIT = 6;
  localparam int INS_CONT_BIT = 7;
  // Engine control fields
  localparam int CTL_START_BIT = 0;
  // ==========================================================================
  // Reset values and instruction decode constants
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [7:0] RST_REPEAT_LIMIT = 8'h01;
  localparam logic [7:0] INSTR_RESV_MASK = 8'h0F;
  localparam logic [7:0] INSTR_END_OP = 8'h00;
  // ==========================================================================
  // Converter result carrier, external RAM write and engine state
  typedef struct packed {
    logic valid;
    logic [15:0] data;
  } cdc_result_t;
  typedef struct packed {
    logic valid;
    logic [15:0] addr;
    logic [15:0] data;
  } cdc_ram_wr_t;
  typedef enum logic [1:0] {
    CDC_IDLE = 2'b00,
    CDC_WAIT = 2'b01,
    CDC_DONE = 2'b10
  } cdc_state_t;
endpackage

/* hdl/cdc_flag.sv */
// Sticky status flag: hardware set wins over software clear.
// Assumes one clock and an active-low asynchronous reset.
`timescale 1ns/1ns
module cdc_flag (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic arst_n,
  // Set and clear
  input wire logic set_i,
  input wire logic clr_i,
  // State
  output logic flag_q
);
  // ==========================================================================
  // Flag storage
  logic flag_d;
  assign flag_d = set_i | (flag_q & ~clr_i); // Set wins, so no event is lost
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      flag_q <= 1'b0;
    end else begin
      flag_q <= flag_d;
    end
  end
endmodule // cdc_flag

/* hdl/cdc_collect.sv */
// Collection selector: picks which converter result is stored for an instruction.
// Assumes converter results arrive as one-cycle valid pulses.
`timescale 1ns/1ns
module cdc_collect (
  // Instruction selection
  input wire logic first_en,
  input wire logic second_en,
  input wire logic diff_en,
  // Converter results
  input cdc_pkg::cdc_result_t first_res,
  input cdc_pkg::cdc_result_t second_res,
  input cdc_pkg::cdc_result_t diff_res,
  // Selected store request
  output logic store_valid,
  output logic [15:0] store_data
);
  // ==========================================================================
  // Selection; differential mode overrides first-converter storage
  logic take_diff;
  logic take_first;
  logic take_second;
  assign take_diff = diff_en & diff_res.valid;
  assign take_first = first_en & ~diff_en & first_res.valid;
  assign take_second = second_en & second_res.valid & ~take_diff & ~take_first;
  assign store_valid = take_diff | take_first | take_second;
  assign store_data = take_diff ? diff_res.data : (take_first ? first_res.data : second_res.data);
endmodule // cdc_collect

/* testbench/cdc_dma_sva.sv */
// Checker for the ports of the converter DMA top.
// Assumes it is bound onto cdc_dma; one clock domain.
`timescale 1ns/1ns
module cdc_dma_sva (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic arst_n,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  // Data and interrupts
  input cdc_pkg::cdc_result_t first_res,
  input cdc_pkg::cdc_result_t second_res,
  input cdc_pkg::cdc_result_t diff_res,
  input cdc_pkg::cdc_ram_wr_t ram_wr,
  input wire logic overflow_irq,
  input wire logic end_op_irq
);
  // ==========================================================================
  // Helpers
  logic [7:0] start_q;
  logic cfg_wr;
  assign cfg_wr = reg_wr && reg_addr == cdc_pkg::ADDR_TRANSFER_CONFIG;
  // Shadow of the start byte; read-back is judged against it
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) start_q <= 8'h00;
    else if (reg_wr && reg_addr == cdc_pkg::ADDR_DATA_START_HIGH) start_q <= reg_wdata;
  end
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!arst_n);
  sequence s_ovf_off;
    cfg_wr && !reg_wdata[3];
  endsequence
  sequence s_eop_off;
    cfg_wr && !reg_wdata[1];
  endsequence
  // ==========================================================================
  // Properties
  AST_OVF_MASK: assert property (s_ovf_off |=> !overflow_irq)
    else $error("overflow irq while disabled");
  AST_EOP_MASK: assert property (s_eop_off |=> !end_op_irq)
    else $error("end op irq while disabled");
  AST_OVF_STICKY: assert property (overflow_irq && !(cfg_wr && !(reg_wdata[2] && reg_wdata[3]))
    |=> overflow_irq)
    else $error("overflow irq dropped");
  AST_EOP_STICKY: assert property (end_op_irq && !(cfg_wr && !(reg_wdata[0] && reg_wdata[1])) |=> end_op_irq)
    else $error("end op irq dropped");
  AST_RD_IDLE: assert property (!reg_rd |=> reg_rdata == 8'h00)
    else $error("read data without read");
  AST_START_RD: assert property (reg_rd && reg_addr == 8'hDA |=> reg_rdata == $past(start_q))
    else $error("start byte read wrong");
  AST_UNMAPPED: assert property (reg_rd && (reg_addr < 8'hD8 || reg_addr > 8'hDD) |=> reg_rdata == 8'h00)
    else $error("unmapped read not zero");
  AST_STORE_CAUSE: assert property (ram_wr.valid |->
    $past(first_res.valid || second_res.valid || diff_res.valid))
    else $error("store without result");
endmodule // cdc_dma_sva

/* testbench/cdc_conv_model.sv */
// Converter model: one result pulse per request bit.
// Assumes requests change just after a rising edge.
`timescale 1ns/1ns
module cdc_conv_model (
  // Clock
  input wire logic ref_clk,
  // Requests: bit0 first, bit1 second, bit2 differential
  input wire logic [2:0] req,
  input wire logic [15:0] value,
  // Results
  output cdc_pkg::cdc_result_t first_res,
  output cdc_pkg::cdc_result_t second_res,
  output cdc_pkg::cdc_result_t diff_res
);
  initial {first_res, second_res, diff_res} = '0;
  // Data toggles between pulses so a stale capture is caught
  // Differential data is byte-swapped so a wrong source pick shows in RAM
  always @(posedge ref_clk) begin
    first_res <= {req[0], req[0] ? value : ~first_res.data};
    second_res <= {req[1], req[1] ? value : ~second_res.data};
    diff_res <= {req[2], req[2] ? {value[7:0], value[15:8]} : ~diff_res.data};
  end
endmodule // cdc_conv_model

/* testbench/tb_top.sv */
// Testbench for the converter DMA block.
// Assumes the design, package, model and checker are compiled first.
`timescale 1ns/1ns
module tb_top;
  logic ref_clk, arst_n, reg_wr, reg_rd, overflow_irq, end_op_irq;
  logic [7:0] reg_addr, reg_wdata, reg_rdata;
  logic [2:0] req;
  logic [15:0] value;
  cdc_pkg::cdc_result_t first_res, second_res, diff_res;
  cdc_pkg::cdc_ram_wr_t ram_wr;
  int error_cnt, total_checks;
  cdc_dma u_cdc_dma (.ref_clk(ref_clk), .arst_n(arst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .first_res(first_res), .second_res(second_res),
    .diff_res(diff_res), .ram_wr(ram_wr), .overflow_irq(overflow_irq), .end_op_irq(end_op_irq));
  cdc_conv_model u_cdc_conv_model (.ref_clk(ref_clk), .req(req), .value(value), .first_res(first_res),
    .second_res(second_res), .diff_res(diff_res));
  initial begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end
  // ==========================================================================
  // Shared tasks
  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    reg_wr <= 1'b1; reg_addr <= a; reg_wdata <= d;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask
  // Read data stands one cycle only, so it is sampled right then
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge ref_clk);
    reg_rd <= 1'b1; reg_addr <= a;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1;
    chk("reg_rdata", {8'h00, reg_rdata}, {8'h00, exp});
  endtask
  task automatic fire(input logic [2:0] s, input logic ev, input logic [15:0] ea);
    logic [15:0] v;
    v = ea ^ 16'h5A5A;
    @(posedge ref_clk);
    req <= s; value <= v;
    @(posedge ref_clk);
    req <= 3'h0;
    @(posedge ref_clk);
    #1;
    chk("ram_wr.valid", {15'h0, ram_wr.valid}, {15'h0, ev});
    if (ev) chk("ram_wr.addr", ram_wr.addr, ea);
    // Any store with a differential pulse present must carry the differential word
    if (ev) chk("ram_wr.data", ram_wr.data, s[2] ? {v[7:0], v[15:8]} : v);
  endtask
  task automatic start(input logic [7:0] ins);
    wr(8'hD9, ins);
    wr(8'hDC, 8'h01);
  endtask
  // ==========================================================================
  // Scenarios
  task automatic t_regs();
    rd(8'hDA, 8'h00);
    rd(8'hDB, 8'h01);
    wr(8'hDA, 8'hA5);
    rd(8'hDA, 8'hA5);
    rd(8'h00, 8'h00);
    $display("test regs done");
  endtask
  task automatic t_end_op();
    wr(8'hD8, 8'h02);
    start(8'h00);
    rd(8'hD8, 8'h03);
    chk("end_op_irq", {15'h0, end_op_irq}, 16'h0001);
    wr(8'hD8, 8'h02);
    #1 chk("end_op_irq", {15'h0, end_op_irq}, 16'h0000);
    wr(8'hD8, 8'h00);
    start(8'h00);
    rd(8'hD8, 8'h01);
    chk("end_op_irq", {15'h0, end_op_irq}, 16'h0000);
    wr(8'hD8, 8'h00);
    $display("test end_op done");
  endtask
  task automatic t_select();
    wr(8'hDB, 8'h10);
    start(8'h50);
    fire(3'h1, 1'b0, 16'h0);
    fire(3'h4, 1'b1, 16'hA500);
    fire(3'h2, 1'b0, 16'h0);
    fire(3'h5, 1'b1, 16'hA501);
    start(8'h20);
    fire(3'h1, 1'b0, 16'h0);
    fire(3'h4, 1'b0, 16'h0);
    fire(3'h2, 1'b1, 16'hA500);
    $display("test select done");
  endtask
  task automatic t_overflow();
    wr(8'hD8, 8'h08);
    wr(8'hDB, 8'h02);
    start(8'h10);
    fire(3'h1, 1'b1, 16'hA500);
    chk("overflow_irq", {15'h0, overflow_irq}, 16'h0000);
    fire(3'h1, 1'b1, 16'hA501);
    chk("overflow_irq", {15'h0, overflow_irq}, 16'h0001);
    fire(3'h1, 1'b0, 16'h0);
    rd(8'hDD, 8'h00);
    wr(8'hD8, 8'h04);
    rd(8'hD8, 8'h04);
    chk("overflow_irq", {15'h0, overflow_irq}, 16'h0000);
    wr(8'hD8, 8'h08);
    rd(8'hD8, 8'h08);
    $display("test overflow done");
  endtask
  task automatic t_continuous();
    wr(8'hDB, 8'h01);
    start(8'h90);
    for (int i = 0; i < 3; i++) fire(3'h1, 1'b1, 16'hA500 + 16'(i));
    chk("overflow_irq", {15'h0, overflow_irq}, 16'h0000);
    rd(8'hDD, 8'h01);
    $display("test continuous done");
  endtask
  // ==========================================================================
  // Run control
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  initial begin
    {arst_n, reg_wr, reg_rd, reg_addr, reg_wdata, req, value} = '0;
    repeat (10) @(posedge ref_clk);
    arst_n <= 1'b1;
    t_regs();
    t_end_op();
    t_select();
    t_overflow();
    t_continuous();
    end_of_test();
  end
  // Whole run is about 115 cycles; this is far beyond it
  initial begin
    #100000;
    error_cnt++;
    end_of_test();
  end
endmodule // tb_top
bind cdc_dma cdc_dma_sva u_cdc_dma_sva (.ref_clk(ref_clk), .arst_n(arst_n), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .first_res(first_res),
  .second_res(second_res), .diff_res(diff_res), .ram_wr(ram_wr), .overflow_irq(overflow_irq),
  .end_op_irq(end_op_irq));
